/* src/readout_consts.svh */
`ifndef READOUT_CONSTS_SVH
`define READOUT_CONSTS_SVH
// ==========================================
// device register offsets
`define OFS_TOTAL_LINES 8'h01
`define OFS_SKIP_PRI 8'h23
`define OFS_SKIP_SEC 8'h25
`define OFS_FRAME_BURST 8'h46
`define OFS_CH_SEL 8'h48
`define OFS_RX_BIAS 8'h4A
`define OFS_IDLE_WORD 8'h4E
`define OFS_EXT_CLK_EN 8'h52
`define OFS_PIX_WIDTH 8'h6F
`define OFS_SYNTH_ON 8'h71
`define OFS_SYNTH_IN 8'h72
`define OFS_SYNTH_SKIP 8'h73
`define OFS_SYNTH_BAND 8'h74
// ==========================================
// device reset values
`define RST_TOTAL_LINES 16'h0440
`define RST_SKIP 16'h0000
`define RST_FRAME_BURST 16'h0001
`define RST_CH_SEL 2'h0
`define RST_RX_BIAS 4'h8
`define RST_IDLE_WORD 12'h055
`define RST_PIX_WIDTH 1'h1
`define RST_SYNTH_ON 1'h1
`define RST_SYNTH_SKIP 1'h0
`define MASK_10BIT 12'h3FF
`define MASK_12BIT 12'hFFF
// ==========================================
// host register offsets and fields
`define HOFS_CTRL 8'h00
`define HOFS_CMD 8'h04
`define HOFS_STATUS 8'h08
`define HOFS_LINES 8'h0C
`define HOFS_PIXEL 8'h10
`define CTRL_FRAME_REQ 0
`define CTRL_LINK_RST 1
`define CMD_READ 31
// ==========================================
// timing
`define ROW_CYCLES 8
`define LINK_HALF_DIV 8
`endif

/* src/readout_pkg.sv */
package readout_pkg;
	typedef enum {S_IDLE, S_LINE, S_GAP} seq_state_t;
	typedef logic [11:0] pix_t;
	typedef logic [15:0] word16_t;
endpackage

/* src/readout_link_if.sv */
`timescale 1ns/1ps
interface readout_link_if #(parameter int LANES = 16);
	// ==========================================
	// clock and reset made by the host end
	logic lclk;
	logic link_rst_n;
	// ==========================================
	// register access and frame request
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic frame_req;
	// ==========================================
	// pixel lanes
	logic [LANES*12-1:0] lane_data;
	logic data_valid;
	logic frame_valid;

	modport device (
		input lclk, link_rst_n, reg_wr, reg_rd, reg_addr, reg_wdata,
		input frame_req,
		output reg_rdata, lane_data, data_valid, frame_valid
	);
	modport host (
		output lclk, link_rst_n, reg_wr, reg_rd, reg_addr, reg_wdata,
		output frame_req,
		input reg_rdata, lane_data, data_valid, frame_valid
	);
endinterface

/* src/readout_sensor.sv */
// Notes on behaviour
// - total line count per frame, reset 1088
// - simple mode: both skip registers equal
// - advanced mode: host keeps primary at zero
// - advanced mode: secondary skip even, 0..1086
// - burst of frames per request, reset 1
// - channel select: 16, 8, 4, 2 lanes
// - idle word sent when no image data
// - idle word 12 or 10 bits, reset 85
// - synthesizer makes serial clock by default
// - synthesizer enable bit, reset on
// - bypass bit, set when synthesizer off
// - synth off: host enables ext clock, bias
// - bias zero turns receiver off, reset 8
// - slower rate only at start-up or reset
// - host picks synth codes by clock band
// - pixel width select, reset 10 bits
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "readout_consts.svh"
module readout_sensor import readout_pkg::*; #(
	parameter int LANES = 16,
	parameter int ROW_CYC = `ROW_CYCLES
) (
	// link
	readout_link_if.device link,
	// clock status
	output logic synth_run,
	output logic synth_bypassed,
	output logic ext_clk_rx_on,
	output logic serial_clk_ok,
	output logic [1:0] synth_in_code,
	output logic [7:0] synth_band
);
	// ==========================================
	// registers
	word16_t lines_r, lines_nxt, skip_p_r, skip_p_nxt;
	word16_t skip_s_r, skip_s_nxt, frames_r, frames_nxt;
	logic [1:0] chsel_r, chsel_nxt, in_r, in_nxt;
	logic [3:0] bias_r, bias_nxt;
	pix_t idle_r, idle_nxt;
	logic ext_r, ext_nxt, pw_r, pw_nxt, on_r, on_nxt, byp_r, byp_nxt;
	logic [7:0] band_r, band_nxt;
	word16_t rdata_r, rdata_nxt;

	always_comb begin
		lines_nxt = lines_r;
		skip_p_nxt = skip_p_r;
		skip_s_nxt = skip_s_r;
		frames_nxt = frames_r;
		chsel_nxt = chsel_r;
		bias_nxt = bias_r;
		idle_nxt = idle_r;
		ext_nxt = ext_r;
		pw_nxt = pw_r;
		on_nxt = on_r;
		in_nxt = in_r;
		byp_nxt = byp_r;
		band_nxt = band_r;
		rdata_nxt = rdata_r;
		if (link.reg_wr) begin
			case (link.reg_addr)
				`OFS_TOTAL_LINES: lines_nxt = link.reg_wdata;
				`OFS_SKIP_PRI: skip_p_nxt = link.reg_wdata;
				`OFS_SKIP_SEC: skip_s_nxt = link.reg_wdata;
				`OFS_FRAME_BURST: frames_nxt = link.reg_wdata;
				`OFS_CH_SEL: chsel_nxt = link.reg_wdata[1:0];
				`OFS_RX_BIAS: bias_nxt = link.reg_wdata[3:0];
				`OFS_IDLE_WORD: idle_nxt = link.reg_wdata[11:0];
				`OFS_EXT_CLK_EN: ext_nxt = link.reg_wdata[0];
				`OFS_PIX_WIDTH: pw_nxt = link.reg_wdata[0];
				`OFS_SYNTH_ON: on_nxt = link.reg_wdata[0];
				`OFS_SYNTH_IN: in_nxt = link.reg_wdata[1:0];
				`OFS_SYNTH_SKIP: byp_nxt = link.reg_wdata[0];
				`OFS_SYNTH_BAND: band_nxt = link.reg_wdata[7:0];
				default: ;
			endcase
		end
		if (link.reg_rd) begin
			case (link.reg_addr)
				`OFS_TOTAL_LINES: rdata_nxt = lines_r;
				`OFS_SKIP_PRI: rdata_nxt = skip_p_r;
				`OFS_SKIP_SEC: rdata_nxt = skip_s_r;
				`OFS_FRAME_BURST: rdata_nxt = frames_r;
				`OFS_CH_SEL: rdata_nxt = {14'h0000, chsel_r};
				`OFS_RX_BIAS: rdata_nxt = {12'h000, bias_r};
				`OFS_IDLE_WORD: rdata_nxt = {4'h0, idle_r};
				`OFS_EXT_CLK_EN: rdata_nxt = {15'h0000, ext_r};
				`OFS_PIX_WIDTH: rdata_nxt = {15'h0000, pw_r};
				`OFS_SYNTH_ON: rdata_nxt = {15'h0000, on_r};
				`OFS_SYNTH_IN: rdata_nxt = {14'h0000, in_r};
				`OFS_SYNTH_SKIP: rdata_nxt = {15'h0000, byp_r};
				`OFS_SYNTH_BAND: rdata_nxt = {8'h00, band_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge link.lclk) begin
		if (!link.link_rst_n) begin
			lines_r <= `RST_TOTAL_LINES;
			skip_p_r <= `RST_SKIP;
			skip_s_r <= `RST_SKIP;
			frames_r <= `RST_FRAME_BURST;
			chsel_r <= `RST_CH_SEL;
			bias_r <= `RST_RX_BIAS;
			idle_r <= `RST_IDLE_WORD;
			ext_r <= 1'b0;
			pw_r <= `RST_PIX_WIDTH;
			on_r <= `RST_SYNTH_ON;
			in_r <= 2'h0;
			byp_r <= `RST_SYNTH_SKIP;
			band_r <= 8'h00;
			rdata_r <= 16'h0000;
		end else begin
			lines_r <= lines_nxt;
			skip_p_r <= skip_p_nxt;
			skip_s_r <= skip_s_nxt;
			frames_r <= frames_nxt;
			chsel_r <= chsel_nxt;
			bias_r <= bias_nxt;
			idle_r <= idle_nxt;
			ext_r <= ext_nxt;
			pw_r <= pw_nxt;
			on_r <= on_nxt;
			in_r <= in_nxt;
			byp_r <= byp_nxt;
			band_r <= band_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign link.reg_rdata = rdata_r;
	// ==========================================
	// serial clock source
	assign synth_run = on_r;
	assign synth_bypassed = byp_r;
	assign ext_clk_rx_on = ext_r && (bias_r != 4'h0);
	// synth path or external path; host must fix both when off
	assign serial_clk_ok = (on_r && !byp_r) || ext_clk_rx_on;
	assign synth_in_code = in_r;
	assign synth_band = band_r;
	// ==========================================
	// sequencer
	seq_state_t st_r, st_nxt;
	logic [10:0] row_r, row_nxt;
	word16_t line_r, line_nxt, fr_r, fr_nxt;
	logic [7:0] col_r, col_nxt;
	logic [10:0] step;

	// secondary holds the skip in both modes; primary must be 0 or equal
	assign step = 11'(skip_s_r) + 11'h001;

	always_comb begin
		st_nxt = st_r;
		row_nxt = row_r;
		line_nxt = line_r;
		fr_nxt = fr_r;
		col_nxt = col_r;
		case (st_r)
			S_IDLE: begin
				if (link.frame_req) begin
					st_nxt = S_LINE;
					row_nxt = 11'h000;
					line_nxt = 16'h0001;
					fr_nxt = 16'h0001;
					col_nxt = 8'h00;
				end
			end
			S_LINE: begin
				col_nxt = col_r + 8'h01;
				if (col_r == 8'(ROW_CYC - 1)) begin
					col_nxt = 8'h00;
					st_nxt = S_GAP;
				end
			end
			S_GAP: begin
				if (line_r < lines_r) begin
					line_nxt = line_r + 16'h0001;
					row_nxt = row_r + step;
					st_nxt = S_LINE;
				end else if (fr_r < frames_r) begin
					fr_nxt = fr_r + 16'h0001;
					line_nxt = 16'h0001;
					row_nxt = 11'h000;
					st_nxt = S_LINE;
				end else begin
					st_nxt = S_IDLE;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// ==========================================
	// lane drive
	logic [LANES*12-1:0] lane_nxt, lane_r;
	logic dval_r, fval_r;
	pix_t mask;
	assign mask = pw_r ? `MASK_10BIT : `MASK_12BIT;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic on_lane;
			pix_t pix;
			// unused lanes are parked low to save power
			assign on_lane = g < (LANES >> chsel_r);
			assign pix = 12'(row_nxt) + 12'(g) + 12'(col_nxt);
			assign lane_nxt[g*12 +: 12] = !on_lane ? 12'h000 :
				(st_nxt == S_LINE) ? (pix & mask) : (idle_r & mask);
		end
	endgenerate

	always_ff @(posedge link.lclk) begin
		if (!link.link_rst_n) begin
			st_r <= S_IDLE;
			row_r <= 11'h000;
			line_r <= 16'h0000;
			fr_r <= 16'h0000;
			col_r <= 8'h00;
			lane_r <= '0;
			dval_r <= 1'b0;
			fval_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			row_r <= row_nxt;
			line_r <= line_nxt;
			fr_r <= fr_nxt;
			col_r <= col_nxt;
			lane_r <= lane_nxt;
			dval_r <= st_nxt == S_LINE;
			fval_r <= st_nxt != S_IDLE;
		end
	end

	assign link.lane_data = lane_r;
	assign link.data_valid = dval_r;
	assign link.frame_valid = fval_r;
endmodule // readout_sensor

/* src/readout_host.sv */
`timescale 1ns/1ps
`include "readout_consts.svh"
module readout_host import readout_pkg::*; #(
	parameter int HALF_DIV = `LINK_HALF_DIV
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// link
	readout_link_if.host link
);
	// ==========================================
	// link clock divider; host acts on the falling phase
	logic [7:0] div_r, div_nxt;
	logic lclk_r, lclk_nxt, fall;
	assign fall = (div_r == 8'(HALF_DIV - 1)) && lclk_r;
	// ==========================================
	// axi and link state
	logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt, cmd_r, cmd_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic req_r, req_nxt, lrst_r, lrst_nxt, busy_r, busy_nxt;
	logic go_r, go_nxt, fq_r, fq_nxt, fpend_r, fpend_nxt;
	word16_t rb_r, rb_nxt, lines_r, lines_nxt;
	pix_t pix_r, pix_nxt;
	logic dv_r, dv_nxt, freq_set;

	always_comb begin
		div_nxt = div_r + 8'h01;
		lclk_nxt = lclk_r;
		if (div_r == 8'(HALF_DIV - 1)) begin
			div_nxt = 8'h00;
			lclk_nxt = !lclk_r;
		end
		aw_nxt = aw_r;
		awa_nxt = awa_r;
		w_nxt = w_r;
		wd_nxt = wd_r;
		bv_nxt = bv_r && !bready;
		br_nxt = br_r;
		rv_nxt = rv_r && !rready;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		cmd_nxt = cmd_r;
		busy_nxt = busy_r;
		lrst_nxt = lrst_r;
		fpend_nxt = fpend_r;
		go_nxt = go_r;
		fq_nxt = fq_r;
		req_nxt = req_r;
		rb_nxt = rb_r;
		lines_nxt = lines_r;
		pix_nxt = pix_r;
		dv_nxt = dv_r;
		freq_set = 1'b0;
		if (awvalid && !aw_r) begin
			aw_nxt = 1'b1;
			awa_nxt = awaddr;
		end
		if (wvalid && !w_r) begin
			w_nxt = 1'b1;
			wd_nxt = wdata;
		end
		if (aw_r && w_r && !bv_r) begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = 2'b00;
			case (awa_r)
				`HOFS_CTRL: begin
					lrst_nxt = wd_r[`CTRL_LINK_RST];
					freq_set = wd_r[`CTRL_FRAME_REQ];
				end
				// a command while busy is dropped
				`HOFS_CMD: if (!busy_r) begin
					cmd_nxt = wd_r;
					busy_nxt = 1'b1;
				end
				`HOFS_STATUS, `HOFS_LINES, `HOFS_PIXEL: ;
				default: br_nxt = 2'b10;
			endcase
		end
		if (arvalid && !rv_r) begin
			rv_nxt = 1'b1;
			rr_nxt = 2'b00;
			case (araddr)
				`HOFS_CTRL: rd_nxt = {30'h00000000, lrst_r, 1'b0};
				`HOFS_CMD: rd_nxt = cmd_r;
				`HOFS_STATUS: rd_nxt = {rb_r, 13'h0000,
					link.frame_valid, fpend_r, busy_r};
				`HOFS_LINES: rd_nxt = {16'h0000, lines_r};
				`HOFS_PIXEL: rd_nxt = {20'h00000, pix_r};
				default: begin
					rd_nxt = 32'h00000000;
					rr_nxt = 2'b10;
				end
			endcase
		end
		// link side: one lclk period per access or request
		if (fall) begin
			go_nxt = 1'b0;
			fq_nxt = 1'b0;
			dv_nxt = link.data_valid;
			if (go_r) begin
				busy_nxt = 1'b0;
				if (cmd_r[`CMD_READ]) rb_nxt = link.reg_rdata;
			end else if (busy_r) begin
				go_nxt = 1'b1;
			end
			if (fpend_r && !fq_r) begin
				fq_nxt = 1'b1;
				fpend_nxt = 1'b0;
				lines_nxt = 16'h0000;
			end
			if (link.data_valid && !dv_r) lines_nxt = lines_nxt + 16'h0001;
			if (link.data_valid) pix_nxt = link.lane_data[11:0];
		end
		// a new request beats the clear of the one being sent
		if (freq_set) fpend_nxt = 1'b1;
		req_nxt = fq_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_r <= 8'h00;
			lclk_r <= 1'b0;
			aw_r <= 1'b0;
			awa_r <= 8'h00;
			w_r <= 1'b0;
			wd_r <= 32'h00000000;
			bv_r <= 1'b0;
			br_r <= 2'b00;
			rv_r <= 1'b0;
			rd_r <= 32'h00000000;
			rr_r <= 2'b00;
			cmd_r <= 32'h00000000;
			busy_r <= 1'b0;
			lrst_r <= 1'b0;
			fpend_r <= 1'b0;
			go_r <= 1'b0;
			fq_r <= 1'b0;
			req_r <= 1'b0;
			rb_r <= 16'h0000;
			lines_r <= 16'h0000;
			pix_r <= 12'h000;
			dv_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			lclk_r <= lclk_nxt;
			aw_r <= aw_nxt;
			awa_r <= awa_nxt;
			w_r <= w_nxt;
			wd_r <= wd_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			cmd_r <= cmd_nxt;
			busy_r <= busy_nxt;
			lrst_r <= lrst_nxt;
			fpend_r <= fpend_nxt;
			go_r <= go_nxt;
			fq_r <= fq_nxt;
			req_r <= req_nxt;
			rb_r <= rb_nxt;
			lines_r <= lines_nxt;
			pix_r <= pix_nxt;
			dv_r <= dv_nxt;
		end
	end

	assign awready = !aw_r;
	assign wready = !w_r;
	assign bvalid = bv_r;
	assign bresp = br_r;
	assign arready = !rv_r;
	assign rvalid = rv_r;
	assign rdata = rd_r;
	assign rresp = rr_r;
	assign link.lclk = lclk_r;
	assign link.link_rst_n = aresetn && !lrst_r;
	assign link.reg_wr = go_r && !cmd_r[`CMD_READ];
	assign link.reg_rd = go_r && cmd_r[`CMD_READ];
	assign link.reg_addr = cmd_r[23:16];
	assign link.reg_wdata = cmd_r[15:0];
	assign link.frame_req = req_r;
endmodule // readout_host

/* tb/readout_link_chk.sv */
`timescale 1ns/1ps
`include "readout_consts.svh"
module readout_link_chk import readout_pkg::*; #(
	parameter int LANES = 16
) (
	// link
	input wire logic lclk,
	input wire logic link_rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic frame_req,
	input wire logic [LANES*12-1:0] lane_data,
	input wire logic data_valid,
	input wire logic frame_valid
);
	// ==========================================
	// shadow of device registers
	pix_t idle_r, idle_nxt, idle_exp;
	logic pixw_r, pixw_nxt, dv_r;
	logic [1:0] chsel_r, chsel_nxt;
	word16_t lines_r, lines_nxt, frames_r, frames_nxt;
	logic [31:0] rows_r, rows_nxt;
	logic [LANES*12-1:0] hi_lanes;

	always_comb begin
		idle_nxt = idle_r;
		pixw_nxt = pixw_r;
		chsel_nxt = chsel_r;
		lines_nxt = lines_r;
		frames_nxt = frames_r;
		if (reg_wr) begin
			case (reg_addr)
				`OFS_IDLE_WORD: idle_nxt = reg_wdata[11:0];
				`OFS_PIX_WIDTH: pixw_nxt = reg_wdata[0];
				`OFS_CH_SEL: chsel_nxt = reg_wdata[1:0];
				`OFS_TOTAL_LINES: lines_nxt = reg_wdata;
				`OFS_FRAME_BURST: frames_nxt = reg_wdata;
				default: ;
			endcase
		end
		// rows of a whole burst, cleared while idle
		rows_nxt = rows_r + 32'(data_valid & ~dv_r);
		if (!frame_valid)
			rows_nxt = 32'h0;
		idle_exp = idle_r & (pixw_r ? `MASK_10BIT : `MASK_12BIT);
		for (int g = 0; g < LANES; g++) begin
			hi_lanes[g*12+:12] = lane_data[g*12+:12];
			if (g < (LANES >> chsel_r))
				hi_lanes[g*12+:12] = 12'h000;
		end
	end

	always_ff @(posedge lclk) begin
		if (!link_rst_n) begin
			idle_r <= `RST_IDLE_WORD;
			pixw_r <= `RST_PIX_WIDTH;
			chsel_r <= `RST_CH_SEL;
			lines_r <= `RST_TOTAL_LINES;
			frames_r <= `RST_FRAME_BURST;
			rows_r <= 32'h0;
			dv_r <= 1'b0;
		end else begin
			idle_r <= idle_nxt;
			pixw_r <= pixw_nxt;
			chsel_r <= chsel_nxt;
			lines_r <= lines_nxt;
			frames_r <= frames_nxt;
			rows_r <= rows_nxt;
			dv_r <= data_valid;
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge lclk); endclocking
	default disable iff (!link_rst_n);

	// lanes lag a register write by one cycle, hence the past terms
	chk_idle_word: assert property (
		!data_valid && $past(link_rst_n) && !$past(reg_wr)
		|-> lane_data[11:0] == idle_exp)
		else $error("idle word wrong on lane 0");
	chk_lane_off: assert property (
		$past(link_rst_n) && !$past(reg_wr)
		|-> hi_lanes == '0)
		else $error("unused lane not quiet");
	chk_row_len: assert property (
		$rose(data_valid) |-> data_valid [*8] ##1 !data_valid)
		else $error("row length wrong");
	chk_row_in_frame: assert property (
		data_valid |-> frame_valid)
		else $error("row outside frame");
	chk_req_start: assert property (
		frame_req && !frame_valid |=> data_valid && frame_valid)
		else $error("frame request not started");
	chk_burst_rows: assert property (
		$fell(frame_valid) |-> rows_r == lines_r * frames_r)
		else $error("row count of burst wrong");
	chk_rd_idle: assert property (
		reg_rd && reg_addr == `OFS_IDLE_WORD |=> reg_rdata[11:0] == idle_r)
		else $error("idle word read back wrong");
	chk_rd_lines: assert property (
		reg_rd && reg_addr == `OFS_TOTAL_LINES |=> reg_rdata == lines_r)
		else $error("line count read back wrong");
endmodule // readout_link_chk

/* tb/readout_sequencer_config_tb_top.sv */
`timescale 1ns/1ps
`include "readout_consts.svh"
module readout_sequencer_config_tb_top import readout_pkg::*; ;
	// ==========================================
	// signals
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, band;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, in_code, r;
	logic synth_run, synth_bypassed, ext_clk_rx_on, serial_clk_ok;
	int n_errors = 0;
	int compares = 0;
	pix_t rows_q [$];
	logic dv_prev = 1'b0;

	readout_link_if #(.LANES(16)) link ();
	readout_host readout_host_i (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(link));
	readout_sensor readout_sensor_i (.link(link),
		.synth_run(synth_run), .synth_bypassed(synth_bypassed),
		.ext_clk_rx_on(ext_clk_rx_on), .serial_clk_ok(serial_clk_ok),
		.synth_in_code(in_code), .synth_band(band));
	readout_link_chk #(.LANES(16)) readout_link_chk_i (.lclk(link.lclk),
		.link_rst_n(link.link_rst_n), .reg_wr(link.reg_wr),
		.reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
		.frame_req(link.frame_req), .lane_data(link.lane_data),
		.data_valid(link.data_valid), .frame_valid(link.frame_valid));

	// ==========================================
	// row start monitor, lane 0 at first cycle of each row
	always @(negedge link.lclk) begin
		if (link.data_valid === 1'b1 && dv_prev !== 1'b1)
			rows_q.push_back(link.lane_data[11:0]);
		dv_prev = link.data_valid;
	end

	// ==========================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// device access through the command register, polled until idle
	task automatic dev(input logic rd, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] rq);
		logic [31:0] st;
		logic [1:0] rs;
		axi_wr(`HOFS_CMD, {rd, 7'h00, a, d}, rs);
		st = 32'h1;
		while (st[0] !== 1'b0)
			axi_rd(`HOFS_STATUS, st, rs);
		rq = st[31:16];
	endtask

	// lanes settle a few link cycles after a register write
	task automatic dw(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] rq;
		dev(1'b0, a, d, rq);
		repeat (3) @(posedge link.lclk);
		@(posedge aclk);
	endtask

	task automatic t_reset();
		logic [7:0] a [12] = '{8'h01, 8'h23, 8'h25, 8'h46, 8'h48, 8'h4A,
			8'h4E, 8'h52, 8'h6F, 8'h71, 8'h73, 8'h00};
		logic [15:0] e [12] = '{16'h0440, 16'h0000, 16'h0000, 16'h0001,
			16'h0000, 16'h0008, 16'h0055, 16'h0000, 16'h0001, 16'h0001,
			16'h0000, 16'h0000};
		logic [15:0] rq;
		foreach (a[i]) begin
			dev(1'b1, a[i], 16'h0000, rq);
			check(rq, e[i]);
		end
		check({synth_run, serial_clk_ok}, 2'h3);
		$display("test reset values done");
	endtask

	task automatic t_idle();
		dw(`OFS_IDLE_WORD, 16'hFABC);
		check(link.lane_data[11:0], 12'h2BC);
		dw(`OFS_PIX_WIDTH, 16'h0000);
		check(link.lane_data[191:180], 12'hABC);
		$display("test idle word done");
	endtask

	task automatic t_chsel();
		int n;
		for (int c = 0; c < 4; c++) begin
			dw(`OFS_CH_SEL, 16'(c));
			n = 16 >> c;
			check(link.lane_data[(n-1)*12+:12], 12'hABC);
			if (n < 16)
				check(link.lane_data[n*12+:12], 12'h000);
		end
		dw(`OFS_CH_SEL, 16'h0000);
		$display("test channel select done");
	endtask

	task automatic t_frame();
		logic [1:0] rs;
		logic [31:0] d;
		dw(`OFS_TOTAL_LINES, 16'h0003);
		// primary left at zero, even skip
		dw(`OFS_SKIP_SEC, 16'h0002);
		dw(`OFS_FRAME_BURST, 16'h0002);
		rows_q.delete();
		axi_wr(`HOFS_CTRL, 32'h1, rs);
		while (link.frame_valid !== 1'b1)
			@(negedge link.lclk);
		while (link.frame_valid !== 1'b0)
			@(negedge link.lclk);
		check(rows_q.size(), 6);
		foreach (rows_q[i])
			check(rows_q[i], (i % 3) * 3);
		axi_rd(`HOFS_LINES, d, rs);
		check(d, 32'h00000006);
		axi_rd(`HOFS_PIXEL, d, rs);
		check(d, 32'h0000000D);
		@(posedge aclk);
		$display("test frame burst done");
	endtask

	task automatic t_simple();
		logic [1:0] rs;
		dw(`OFS_SKIP_PRI, 16'h0001);
		dw(`OFS_SKIP_SEC, 16'h0001);
		dw(`OFS_FRAME_BURST, 16'h0001);
		rows_q.delete();
		axi_wr(`HOFS_CTRL, 32'h1, rs);
		while (link.frame_valid !== 1'b1)
			@(negedge link.lclk);
		while (link.frame_valid !== 1'b0)
			@(negedge link.lclk);
		check(rows_q.size(), 3);
		foreach (rows_q[i])
			check(rows_q[i], i * 2);
		@(posedge aclk);
		$display("test simple subsampling done");
	endtask

	task automatic t_synth();
		dw(`OFS_SYNTH_ON, 16'h0000);
		check({synth_run, serial_clk_ok}, 2'h0);
		dw(`OFS_SYNTH_SKIP, 16'h0001);
		check(synth_bypassed, 1'b1);
		dw(`OFS_EXT_CLK_EN, 16'h0001);
		check({ext_clk_rx_on, serial_clk_ok}, 2'h3);
		dw(`OFS_RX_BIAS, 16'h0000);
		check({ext_clk_rx_on, serial_clk_ok}, 2'h0);
		dw(`OFS_SYNTH_IN, 16'h0003);
		// 7.5 to 10 MHz band: range 1, out 2, in 3
		dw(`OFS_SYNTH_BAND, 16'h00A0);
		check({in_code, band}, 10'h3A0);
		$display("test synthesizer done");
	endtask

	task automatic t_axi();
		logic [31:0] d;
		logic [1:0] rs;
		axi_wr(8'h20, 32'h1234_5678, rs);
		check(rs, 2'h2);
		axi_rd(8'h20, d, rs);
		check({d[29:0], rs}, 32'h2);
		$display("test unmapped access done");
	endtask

	// ==========================================
	// clock, watchdog, sequence
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial begin
		#300000;
		n_errors++;
		summarize();
	end

	initial begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// link clock may be still in reset, so pulse link reset too
		// data rate stays as set at start-up
		axi_wr(`HOFS_CTRL, 32'h2, r);
		repeat (3) @(posedge link.lclk);
		@(posedge aclk);
		axi_wr(`HOFS_CTRL, 32'h0, r);
		repeat (3) @(posedge link.lclk);
		@(posedge aclk);
		t_reset();
		t_idle();
		t_chsel();
		t_frame();
		t_simple();
		t_synth();
		t_axi();
		summarize();
	end
endmodule // readout_sequencer_config_tb_top
